// [logic/ecp_defs.svh]
/*
 * Egress path constants: cell geometry, header fields, fillers, resets.
 * Assumes inclusion by bare name.
 */
`ifndef ECP_DEFS_SVH
`define ECP_DEFS_SVH

// Cell geometry in octets.
`define ECP_HDR_OCTETS 6'd4
`define ECP_HEC_OCTET 6'd4
`define ECP_LAST_OCTET 6'd52
// Stored cell: header and payload, no HEC.
`define ECP_CELL_BITS 416
`define ECP_PAY_BITS 384
// Header field positions.
`define ECP_GFC_MSB 31
`define ECP_GFC_LSB 28
`define ECP_VCI_MSB 19
`define ECP_VCI_LSB 4
`define ECP_PTI_MSB 3
`define ECP_PTI_LSB 1
`define ECP_CLP_BIT 0
`define ECP_PTI_MID 2
// Special PTI and VCI codes.
`define ECP_PTI_SEG_OAM 3'h4
`define ECP_PTI_E2E_OAM 3'h5
`define ECP_PTI_SIX 3'h6
`define ECP_PTI_SEVEN 3'h7
`define ECP_VCI_SEG_OAM 16'h0003
`define ECP_VCI_E2E_OAM 16'h0004
`define ECP_VCI_RSV_TOP 16'h001f
// CRC-10 generator and good residue.
`define ECP_CRC10_POLY 10'h233
`define ECP_CRC10_GOOD 10'h000
// Filler cell headers and payload octet.
`define ECP_UNASSIGNED_HDR 32'h00000000
`define ECP_IDLE_HDR 32'h00000001
`define ECP_FILL_OCTET 8'h6a
// Reset values.
`define ECP_LIMIT_RESET 16'h0000
`define ECP_FILL_RESET 16'h0000

`endif

// [logic/ecp_pkg.sv]
/*
 * Types of the egress cell processing path.
 * Assumes ecp_defs.svh is available on the include path.
 */
`default_nettype none
package ecp_pkg;
    // Link-side transmit sequencer states, one-hot.
    typedef enum logic [1:0] {
        ECP_TX_IDLE = 2'b01,
        ECP_TX_SEND = 2'b10
    } ecp_tx_state_t;
    // Source chosen for a processing slot, one-hot.
    typedef enum logic [3:0] {
        ECP_SRC_NONE = 4'b0001,
        ECP_SRC_INS = 4'b0010,
        ECP_SRC_SW = 4'b0100,
        ECP_SRC_SKIP = 4'b1000
    } ecp_src_t;
endpackage
`default_nettype wire

// [logic/ecp_sync.sv]
/*
 * Two flip-flop synchroniser for gray pointers and static levels.
 * Assumes an async active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module ecp_sync #(
    parameter int WIDTH = 1
) (
    // Destination clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Source level and its synchronised copy.
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    // First stage, read only by the second stage.
    logic [WIDTH-1:0] meta;

    // Two stages clear to zero on reset.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // ecp_sync
`default_nettype wire

// [logic/ecp_egress_path.sv]
/*
 * Egress cell path: one decision per cell slot,
 * a small transmit FIFO and a UTOPIA octet
 * transmit port on the link clock.
 * Assumes queues hold a cell while valid;
 * counters and extraction sit outside.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ecp_defs.svh"
module ecp_egress_path #(
    parameter int SLOT_CYCLES = 56,
    parameter int NLINK = 4,
    parameter int LW = 2
) (
    // Data-path clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Insertion bucket configuration and state.
    input wire logic limit_wr,
    input wire logic [15:0] limit_wdata,
    input wire logic [15:0] avg_insert_period,
    output logic [15:0] insert_bucket_fill,
    // Global configuration levels.
    input wire logic multi_link,
    input wire logic [NLINK-1:0] link_enable_reg,
    input wire logic translation_disable,
    input wire logic replace_gfc,
    input wire logic tx_fifo_depth_sel,
    input wire logic fill_enable,
    input wire logic idle_fill_select,
    input wire logic billing_table_en,
    input wire logic link_table_en,
    input wire logic [31:0] reserved_vci_copy_mask,
    input wire logic [31:0] reserved_vci_remove_mask,
    // Switch-side cell and its context.
    input wire logic sw_valid,
    output logic sw_take,
    input wire logic [31:0] sw_header,
    input wire logic [`ECP_PAY_BITS-1:0] sw_payload,
    input wire logic sw_efci,
    input wire logic [LW-1:0] sw_link_num,
    input wire logic copy_all_cells,
    input wire logic remove_all_cells,
    input wire logic reserved_vci_enable,
    input wire logic pti_six_copy,
    input wire logic pti_seven_copy,
    input wire logic conn_is_vpc,
    input wire logic link_is_uni,
    input wire logic seg_term_point,
    input wire logic e2e_term_point,
    input wire logic oam_illegal,
    input wire logic [27:0] translate_word,
    // Insert queues, index 0 monitoring, 1 processor, 2 alarms.
    input wire logic [2:0] ins_valid,
    output logic [2:0] ins_take,
    input wire logic [31:0] ins_header [3],
    input wire logic [`ECP_PAY_BITS-1:0] ins_payload [3],
    // Extraction and counting strobes.
    output logic extract_copy,
    output logic cell_removed,
    output logic billing_inc,
    output logic link_cnt_inc,
    output logic [1:0] count_sel,
    output logic [LW-1:0] count_link,
    output logic slot_skipped,
    // UTOPIA transmit port.
    input wire logic txclk,
    input wire logic tx_clav,
    output logic tx_enb_n,
    output logic tx_soc,
    output logic [7:0] tx_data,
    output logic tx_prty
);
    // Slot counter and slot start tick.
    logic [15:0] slot_cnt;
    logic slot_tick;
    // Bucket limit written by software.
    logic [15:0] insert_bucket_limit;
    // Transmit FIFO storage and pointers.
    logic [`ECP_CELL_BITS-1:0] fifo_mem [4];
    logic [2:0] wr_bin;
    logic [2:0] wr_gray;
    logic [2:0] rd_bin;
    logic [2:0] rd_gray;
    logic [2:0] rd_gray_m;
    logic [2:0] wr_gray_t;
    logic [2:0] rd_bin_m;
    logic [2:0] fifo_count;
    logic fifo_full;
    // Slot decision terms.
    ecp_pkg::ecp_src_t src;
    logic ins_ok;
    logic [2:0] ins_pick;
    logic [31:0] cell_hdr;
    logic [`ECP_PAY_BITS-1:0] cell_pay;
    logic is_oam;
    logic is_seg;
    logic is_e2e;
    logic crc_bad;
    logic rsv_vci;
    logic link_off;
    logic do_copy;
    logic do_remove;
    logic [31:0] out_hdr;
    logic [2:0] pti;
    logic [15:0] vci;

    // Slot counter; each wrap starts a slot.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            slot_cnt <= 16'h0000;
        end else if (slot_tick) begin
            slot_cnt <= 16'h0000;
        end else begin
            slot_cnt <= slot_cnt + 16'h0001;
        end
    end
    assign slot_tick = (slot_cnt == 16'(SLOT_CYCLES - 1));

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            insert_bucket_limit <= `ECP_LIMIT_RESET;
        end else if (limit_wr) begin
            insert_bucket_limit <= limit_wdata;
        end
    end

    assign ins_ok = (insert_bucket_fill < insert_bucket_limit);

    // Picks one queue; lowest index wins.
    always_comb begin
        ins_pick = 3'h0;
        if (ins_valid[0]) begin
            ins_pick = 3'h1;
        end else if (ins_valid[1]) begin
            ins_pick = 3'h2;
        end else if (ins_valid[2]) begin
            ins_pick = 3'h4;
        end
    end

    // Chooses the slot's source; full FIFO wins.
    always_comb begin
        if (fifo_full) begin
            src = ecp_pkg::ECP_SRC_SKIP;
        end else if (ins_ok && (ins_valid != 3'h0)) begin
            src = ecp_pkg::ECP_SRC_INS;
        end else if (sw_valid) begin
            src = ecp_pkg::ECP_SRC_SW;
        end else begin
            src = ecp_pkg::ECP_SRC_NONE;
        end
    end

    // Selects the cell that the slot works on.
    always_comb begin
        cell_hdr = sw_header;
        cell_pay = sw_payload;
        if (src == ecp_pkg::ECP_SRC_INS) begin
            if (ins_pick[0]) begin
                cell_hdr = ins_header[0];
                cell_pay = ins_payload[0];
            end else if (ins_pick[1]) begin
                cell_hdr = ins_header[1];
                cell_pay = ins_payload[1];
            end else begin
                cell_hdr = ins_header[2];
                cell_pay = ins_payload[2];
            end
        end
    end

    // CRC-10 residue over the payload; zero is intact.
    function automatic logic [9:0] crc10(input logic [`ECP_PAY_BITS-1:0] d);
        logic [9:0] c;
        logic fb;
        c = 10'h000;
        for (int i = `ECP_PAY_BITS - 1; i >= 0; i--) begin
            fb = c[9] ^ d[i];
            c = {c[8:0], 1'b0};
            if (fb) begin
                c = c ^ `ECP_CRC10_POLY;
            end
        end
        return c;
    endfunction

    // Classifies the cell; forms copy/remove decisions.
    always_comb begin
        pti = sw_header[`ECP_PTI_MSB:`ECP_PTI_LSB];
        vci = sw_header[`ECP_VCI_MSB:`ECP_VCI_LSB];
        is_seg = (conn_is_vpc && vci == `ECP_VCI_SEG_OAM) ||
                 (!conn_is_vpc && pti == `ECP_PTI_SEG_OAM);
        is_e2e = (conn_is_vpc && vci == `ECP_VCI_E2E_OAM) ||
                 (!conn_is_vpc && pti == `ECP_PTI_E2E_OAM);
        is_oam = is_seg || is_e2e;
        crc_bad = is_oam && (oam_illegal || crc10(sw_payload) != `ECP_CRC10_GOOD);
        rsv_vci = !conn_is_vpc && (vci <= `ECP_VCI_RSV_TOP) && !is_oam;
        link_off = multi_link && !link_enable_reg[sw_link_num];
        do_copy = link_off || crc_bad;
        do_remove = link_off || crc_bad;
        do_copy = do_copy || copy_all_cells;
        do_remove = do_remove || remove_all_cells;
        if (rsv_vci && reserved_vci_enable) begin
            do_copy = do_copy || reserved_vci_copy_mask[vci[4:0]];
            do_remove = do_remove || reserved_vci_remove_mask[vci[4:0]];
        end
        do_copy = do_copy || (pti == `ECP_PTI_SIX && pti_six_copy) ||
                  (pti == `ECP_PTI_SEVEN && pti_seven_copy);
        if (!crc_bad && ((is_seg && seg_term_point) || (is_e2e && e2e_term_point))) begin
            do_remove = 1'b1;
        end
    end

    // Outgoing header of a switch cell.
    always_comb begin
        out_hdr = sw_header;
        if (!translation_disable) begin
            if (conn_is_vpc) begin
                out_hdr[27:20] = translate_word[23:16];
                if (!link_is_uni) begin
                    out_hdr[31:28] = translate_word[27:24];
                end
            end else begin
                out_hdr[27:4] = translate_word[23:0];
                if (!link_is_uni) begin
                    out_hdr[31:28] = translate_word[27:24];
                end
            end
            if (link_is_uni && replace_gfc) begin
                out_hdr[`ECP_GFC_MSB:`ECP_GFC_LSB] = translate_word[27:24];
            end
        end
        if (sw_efci && !pti[2] && !pti[1]) begin
            out_hdr[`ECP_PTI_MID] = 1'b1;
        end
    end

    // Take strobes fire at the slot tick.
    // single queue take
    assign ins_take = (slot_tick && src == ecp_pkg::ECP_SRC_INS) ? ins_pick : 3'h0;
    assign sw_take = slot_tick && (src == ecp_pkg::ECP_SRC_SW);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            insert_bucket_fill <= `ECP_FILL_RESET;
        end else if (slot_tick) begin
            insert_bucket_fill <= insert_bucket_fill
                - ((insert_bucket_fill != 16'h0000) ? 16'h0001 : 16'h0000)
                + ((src == ecp_pkg::ECP_SRC_INS) ? avg_insert_period : 16'h0000);
        end
    end

    // Per-slot strobes toward extraction and counters.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            extract_copy <= 1'b0;
            cell_removed <= 1'b0;
            billing_inc <= 1'b0;
            link_cnt_inc <= 1'b0;
            count_sel <= 2'h0;
            count_link <= '0;
            slot_skipped <= 1'b0;
        end else begin
            extract_copy <= sw_take && do_copy;
            cell_removed <= sw_take && do_remove;
            slot_skipped <= slot_tick && (src == ecp_pkg::ECP_SRC_SKIP);
            billing_inc <= billing_table_en && (ins_take != 3'h0 || (sw_take && !do_remove));
            link_cnt_inc <= link_table_en && (ins_take != 3'h0 || (sw_take && !do_remove));
            count_sel <= {(src == ecp_pkg::ECP_SRC_INS) ? 1'b1 : is_oam,
                          cell_hdr[`ECP_CLP_BIT]};
            count_link <= sw_link_num;
        end
    end

    // Writes accepted cells; no HEC is stored.
    always_ff @(posedge mclk) begin
        if (ins_take != 3'h0) begin
            fifo_mem[wr_bin[1:0]] <= {cell_hdr, cell_pay};
        end else if (sw_take && !do_remove) begin
            fifo_mem[wr_bin[1:0]] <= {out_hdr, sw_payload};
        end
    end

    // Write pointer, binary and gray.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_bin <= 3'h0;
            wr_gray <= 3'h0;
        end else if (ins_take != 3'h0 || (sw_take && !do_remove)) begin
            wr_bin <= wr_bin + 3'h1;
            wr_gray <= (wr_bin + 3'h1) ^ ((wr_bin + 3'h1) >> 1);
        end
    end

    // Read pointer crosses into the data-path domain.
    ecp_sync #(.WIDTH(3)) u_rd_sync (
        .clk(mclk),
        .reset(reset),
        .din(rd_gray),
        .dout(rd_gray_m)
    );

    always_comb begin
        rd_bin_m[2] = rd_gray_m[2];
        rd_bin_m[1] = rd_gray_m[2] ^ rd_gray_m[1];
        rd_bin_m[0] = rd_gray_m[2] ^ rd_gray_m[1] ^ rd_gray_m[0];
        fifo_count = wr_bin - rd_bin_m;
        fifo_full = tx_fifo_depth_sel ? (fifo_count >= 3'h4) : (fifo_count >= 3'h2);
    end

    // Link clock domain.
    ecp_pkg::ecp_tx_state_t tx_state;
    logic [5:0] octet_idx;
    logic [`ECP_CELL_BITS-1:0] tx_cell;
    logic [7:0] next_data;
    logic [1:0] cfg_t;
    logic fill_ok;

    // Write pointer crosses into the link domain.
    ecp_sync #(.WIDTH(3)) u_wr_sync (
        .clk(txclk),
        .reset(reset),
        .din(wr_gray),
        .dout(wr_gray_t)
    );

    // Filler controls cross as levels.
    ecp_sync #(.WIDTH(2)) u_cfg_sync (
        .clk(txclk),
        .reset(reset),
        .din({fill_enable && !multi_link, idle_fill_select}),
        .dout(cfg_t)
    );
    assign fill_ok = cfg_t[1];

    // Picks the octet sent next: header, zero HEC, then payload.
    always_comb begin
        if (octet_idx == `ECP_HEC_OCTET) begin
            next_data = 8'h00;
        end else if (octet_idx < `ECP_HDR_OCTETS) begin
            next_data = tx_cell[`ECP_CELL_BITS - 1 - 8 * octet_idx -: 8];
        end else begin
            next_data = tx_cell[`ECP_CELL_BITS - 1 - 8 * (octet_idx - 6'd1) -: 8];
        end
    end

    // Transmit sequencer: starts a cell on room.
    always_ff @(posedge txclk or posedge reset) begin
        if (reset) begin
            tx_state <= ecp_pkg::ECP_TX_IDLE;
            octet_idx <= 6'h00;
            tx_cell <= '0;
            rd_bin <= 3'h0;
            rd_gray <= 3'h0;
        end else begin
            case (tx_state)
                ecp_pkg::ECP_TX_IDLE: begin
                    octet_idx <= 6'h00;
                    if (tx_clav && wr_gray_t != rd_gray) begin
                        tx_cell <= fifo_mem[rd_bin[1:0]];
                        rd_bin <= rd_bin + 3'h1;
                        rd_gray <= (rd_bin + 3'h1) ^ ((rd_bin + 3'h1) >> 1);
                        tx_state <= ecp_pkg::ECP_TX_SEND;
                    end else if (tx_clav && fill_ok) begin
                        tx_cell <= {cfg_t[0] ? `ECP_IDLE_HDR : `ECP_UNASSIGNED_HDR,
                                    {48{`ECP_FILL_OCTET}}};
                        tx_state <= ecp_pkg::ECP_TX_SEND;
                    end
                end
                ecp_pkg::ECP_TX_SEND: begin
                    if (octet_idx == `ECP_LAST_OCTET) begin
                        tx_state <= ecp_pkg::ECP_TX_IDLE;
                    end
                    octet_idx <= octet_idx + 6'h01;
                end
                default: begin
                    tx_state <= ecp_pkg::ECP_TX_IDLE;
                end
            endcase
        end
    end

    // Registered port outputs toward the PHY.
    always_ff @(posedge txclk or posedge reset) begin
        if (reset) begin
            tx_enb_n <= 1'b1;
            tx_soc <= 1'b0;
            tx_data <= 8'h00;
            tx_prty <= 1'b1;
        end else begin
            tx_enb_n <= (tx_state != ecp_pkg::ECP_TX_SEND);
            tx_soc <= (tx_state == ecp_pkg::ECP_TX_SEND) && (octet_idx == 6'h00);
            tx_data <= (tx_state == ecp_pkg::ECP_TX_SEND) ? next_data : 8'h00;
            tx_prty <= ~^((tx_state == ecp_pkg::ECP_TX_SEND) ? next_data : 8'h00);
        end
    end
endmodule // ecp_egress_path
`default_nettype wire

// [sim/ecp_egress_props.sv]
/* Port checker of the egress path.
   Assumes a bind into ecp_egress_path. */
`timescale 1ns/10ps
`default_nettype none
module ecp_egress_props #(
    parameter int NLINK = 4,
    parameter int LW = 2
) (
    // Clocks and reset.
    input wire logic mclk,
    input wire logic txclk,
    input wire logic reset,
    // Slot decisions and their causes.
    input wire logic sw_take,
    input wire logic [2:0] ins_valid,
    input wire logic [2:0] ins_take,
    input wire logic [LW-1:0] sw_link_num,
    input wire logic [NLINK-1:0] link_enable_reg,
    input wire logic multi_link,
    input wire logic copy_all_cells,
    input wire logic [15:0] avg_insert_period,
    input wire logic [15:0] insert_bucket_fill,
    // Pulses one cycle after the slot.
    input wire logic extract_copy,
    input wire logic cell_removed,
    input wire logic billing_inc,
    input wire logic link_cnt_inc,
    input wire logic slot_skipped,
    // Link side.
    input wire logic tx_enb_n,
    input wire logic tx_soc,
    input wire logic [7:0] tx_data,
    input wire logic tx_prty
);
    // Data-path clock and reset.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    property p_hole; |ins_take |-> !sw_take; endproperty
    a_hole: assert property (p_hole) else $error("insert with switch take");
    property p_prio; |ins_take |-> ins_take == (ins_valid & (~ins_valid + 3'h1)); endproperty
    a_prio: assert property (p_prio) else $error("wrong insert queue");
    property p_fill; |ins_take |=> insert_bucket_fill == 16'($past(insert_bucket_fill)
        + $past(avg_insert_period) - 16'($past(insert_bucket_fill) != 16'h0000)); endproperty
    a_fill: assert property (p_fill) else $error("bucket fill step wrong");
    property p_skip; slot_skipped |-> !$past(sw_take) && $past(ins_take) == 3'h0; endproperty
    a_skip: assert property (p_skip) else $error("skipped slot took a cell");
    property p_link; sw_take && multi_link && !link_enable_reg[sw_link_num]
        |=> cell_removed && extract_copy; endproperty
    a_link: assert property (p_link) else $error("disabled link cell kept");
    property p_copy; sw_take && copy_all_cells |=> extract_copy; endproperty
    a_copy: assert property (p_copy) else $error("copy all not copied");
    property p_nocnt; cell_removed |-> !billing_inc && !link_cnt_inc; endproperty
    a_nocnt: assert property (p_nocnt) else $error("removed cell counted");
    // Link properties run on the link clock.
    property p_par; @(posedge txclk) disable iff (reset) ^{tx_data, tx_prty}; endproperty
    a_par: assert property (p_par) else $error("parity not odd");
    property p_hec; @(posedge txclk) disable iff (reset)
        tx_soc && !tx_enb_n |-> ##4 tx_data == 8'h00 && !tx_enb_n; endproperty
    a_hec: assert property (p_hec) else $error("fifth octet not zero");
    property p_frame; @(posedge txclk) disable iff (reset) $fell(tx_enb_n) |-> tx_soc;
    endproperty
    a_frame: assert property (p_frame) else $error("cell without start");
    c_ins: cover property (|ins_take);
    c_skip: cover property (slot_skipped);
    c_rm: cover property (cell_removed);
endmodule // ecp_egress_props
bind ecp_egress_path ecp_egress_props #(.NLINK(NLINK), .LW(LW)) chk_i (.*);
`default_nettype wire

// [sim/ecp_phy_model.sv]
/* PHY model: offers room unless stalled, keeps the last header.
   Assumes tb makes the link clock. */
`timescale 1ns/10ps
`default_nettype none
module ecp_phy_model (
    // Link clock, reset, stall.
    input wire logic txclk,
    input wire logic reset,
    input wire logic stall,
    // Transmit port.
    input wire logic tx_enb_n,
    input wire logic tx_soc,
    input wire logic [7:0] tx_data,
    output logic tx_clav,
    // Observations.
    output logic [31:0] hdr,
    output int cells
);
    int idx;
    int pos;
    // Header is octets 0-3; a cell ends at octet 52.
    always @(posedge txclk or posedge reset) begin
        if (reset) begin
            tx_clav <= 1'b0;
            hdr <= 32'h00000000;
            cells <= 0;
            idx <= 0;
        end else begin
            tx_clav <= !stall;
            if (!tx_enb_n) begin
                pos = tx_soc ? 0 : idx;
                if (pos < 4)
                    hdr <= {hdr[23:0], tx_data};
                if (pos == 52)
                    cells <= cells + 1;
                idx <= pos + 1;
            end
        end
    end
endmodule // ecp_phy_model
`default_nettype wire

// [sim/tb.sv]
/* Self-checking egress path bench.
   Assumes model and checker are compiled too. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    // Clocks, reset and counters.
    logic mclk = 0, txclk = 0, reset = 1, stall = 0;
    int err_total = 0, checked = 0, cells, n_take = 0, n_ins = 0, n_cp = 0, n_rm = 0;
    int n_sk = 0, n_bl = 0;
    // Design inputs and outputs.
    logic limit_wr = 0, multi_link = 0, translation_disable = 0, replace_gfc = 0;
    logic tx_fifo_depth_sel = 0, fill_enable = 0, idle_fill_select = 0, billing_table_en = 1;
    logic link_table_en = 1, sw_valid = 0, sw_efci = 0, copy_all_cells = 0, off;
    logic remove_all_cells = 0, reserved_vci_enable = 0, pti_six_copy = 0, pti_seven_copy = 0;
    logic conn_is_vpc = 0, link_is_uni = 0, seg_term_point = 0, e2e_term_point = 0;
    logic oam_illegal = 0, sw_take, extract_copy, cell_removed, billing_inc, link_cnt_inc;
    logic slot_skipped, tx_clav, tx_enb_n, tx_soc, tx_prty;
    logic [15:0] limit_wdata = 16'h0000, avg_insert_period = 16'h0010, insert_bucket_fill;
    logic [3:0] link_enable_reg = 4'hf;
    logic [31:0] reserved_vci_copy_mask = 32'h00000020, reserved_vci_remove_mask = 32'h00000020;
    logic [31:0] sw_header = 32'h0, hdr;
    logic [383:0] sw_payload = '0;
    logic [1:0] sw_link_num = 2'h1, count_sel, count_link;
    logic [27:0] translate_word = 28'h9550123;
    logic [2:0] ins_valid = 3'h0, ins_take;
    logic [31:0] ins_header [3] = '{32'h0a000010, 32'h0b000020, 32'h0c000030};
    logic [383:0] ins_payload [3] = '{default: '0};
    logic [7:0] tx_data;
    initial forever #4 mclk = ~mclk;
    initial forever #62.5 txclk = ~txclk;
    ecp_egress_path #(.SLOT_CYCLES(56), .NLINK(4), .LW(2)) dut (.*);
    ecp_phy_model phy (.txclk(txclk), .reset(reset), .stall(stall), .tx_enb_n(tx_enb_n),
        .tx_soc(tx_soc), .tx_data(tx_data), .tx_clav(tx_clav), .hdr(hdr), .cells(cells));
    // Count slot decisions and pulses.
    always @(posedge mclk) begin
        n_take <= n_take + (sw_take === 1'b1);
        n_ins <= n_ins + (ins_take !== 3'h0);
        n_cp <= n_cp + (extract_copy === 1'b1);
        n_rm <= n_rm + (cell_removed === 1'b1);
        n_sk <= n_sk + (slot_skipped === 1'b1);
        n_bl <= n_bl + (billing_inc === 1'b1);
    end
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic conclude();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Offer a switch cell until taken.
    task automatic send(input logic [31:0] h);
        int i, t;
        @(negedge mclk);
        t = n_take;
        sw_header = h;
        sw_valid = 1;
        for (i = 0; i < 3000 && n_take == t; i++) @(negedge mclk);
        sw_valid = 0;
        if (n_take == t) begin
            chk(1'b0, "switch cell not taken");
            conclude();
        end
    endtask
    task automatic wait_cells(input int n);
        int i;
        for (i = 0; i < 20000 && cells < n; i++) @(negedge mclk);
        if (cells < n) begin
            chk(1'b0, "link timeout");
            conclude();
        end
    endtask
    // Header rewrite cases.
    task automatic t_pass();
        logic [3:0] c [5] = '{4'b0010, 4'b0100, 4'b0001, 4'b1000, 4'b0001};
        logic [31:0] e [5] = '{32'h95501234, 32'h95500400, 32'h15501230, 32'h12200400,
            32'h95501230};
        int k, b;
        for (k = 0; k < 5; k++) begin
            {translation_disable, conn_is_vpc, sw_efci, link_is_uni} = c[k];
            replace_gfc = (k == 4);
            b = n_bl;
            send(32'h12200400);
            wait_cells(cells + 1);
            chk(hdr === e[k], "outgoing header");
            chk(n_bl - b == 1, "billing count");
        end
        {translation_disable, conn_is_vpc, sw_efci, link_is_uni} = 4'h0;
        $display("t_pass done");
    endtask
    // Copy/remove decisions from a control table.
    task automatic t_copy();
        logic [7:0] c [9] = '{8'h80, 8'h40, 8'h01, 8'h20, 8'h10, 8'h08, 8'h00, 8'h04, 8'h02};
        logic [31:0] h [9] = '{32'h02200400, 32'h02200400, 32'h02200400, 32'h0220040c,
            32'h0220040e, 32'h02200050, 32'h02200050, 32'h02200408, 32'h02200408};
        logic [1:0] e [9] = '{2'h2, 2'h1, 2'h3, 2'h2, 2'h2, 2'h3, 2'h0, 2'h3, 2'h1};
        int k, a, r, n;
        n = cells;
        multi_link = 1;
        for (k = 0; k < 9; k++) begin
            {copy_all_cells, remove_all_cells, pti_six_copy, pti_seven_copy,
                reserved_vci_enable, oam_illegal, seg_term_point, off} = c[k];
            link_enable_reg = off ? 4'hd : 4'hf;
            a = n_cp;
            r = n_rm;
            send(h[k]);
            repeat (3) @(negedge mclk);
            chk({n_cp - a == 1, n_rm - r == 1} === e[k], "copy remove");
        end
        {copy_all_cells, remove_all_cells, pti_six_copy, pti_seven_copy,
            reserved_vci_enable, oam_illegal, seg_term_point, off} = 8'h00;
        multi_link = 0;
        link_enable_reg = 4'hf;
        wait_cells(n + 4);
        $display("t_copy done");
    endtask
    // Insertion: blocked at zero limit, then top queue.
    task automatic t_ins();
        int k, b, n;
        n = cells;
        b = n_ins;
        ins_valid = 3'h7;
        repeat (200) @(negedge mclk);
        chk(n_ins == b, "insert with zero limit");
        limit_wdata = 16'h0100;
        limit_wr = 1;
        @(negedge mclk);
        limit_wr = 0;
        b = n_bl;
        for (k = 0; k < 200 && ins_take === 3'h0; k++) @(negedge mclk);
        chk(ins_take === 3'h1, "insert queue order");
        @(negedge mclk);
        ins_valid = 3'h0;
        chk(insert_bucket_fill === 16'h0010, "bucket rise");
        repeat (56) @(negedge mclk);
        chk(insert_bucket_fill === 16'h000f, "bucket fall");
        wait_cells(n + 1);
        chk(hdr === ins_header[0] && n_bl - b == 1, "inserted cell counted");
        $display("t_ins done");
    endtask
    // Stalled link: FIFO fills to depth, then slots skip.
    task automatic t_full();
        int d, t, s, n;
        for (d = 0; d < 2; d++) begin
            tx_fifo_depth_sel = d[0];
            stall = 1;
            n = cells;
            repeat (40) @(negedge mclk);
            t = n_take;
            s = n_sk;
            sw_header = 32'h02200400;
            sw_valid = 1;
            repeat (600) @(negedge mclk);
            sw_valid = 0;
            chk(n_take - t == 2 + 2 * d, "fifo depth");
            chk(n_sk > s, "no skipped slot");
            stall = 0;
            wait_cells(n + 2 + 2 * d);
        end
        $display("t_full done");
    endtask
    // Both filler kinds on an empty FIFO.
    task automatic t_fill();
        int k;
        fill_enable = 1;
        for (k = 0; k < 2; k++) begin
            idle_fill_select = k[0];
            wait_cells(cells + 2);
            chk(hdr === {31'h0, k[0]}, "filler header");
        end
        fill_enable = 0;
        $display("t_fill done");
    endtask
    // Reset, then the scenarios.
    initial begin
        repeat (2) @(posedge txclk);
        @(negedge mclk);
        chk(insert_bucket_fill === 16'h0 && tx_enb_n === 1'b1 && tx_prty === 1'b1, "reset");
        reset = 0;
        t_pass();
        t_copy();
        t_ins();
        t_full();
        t_fill();
        conclude();
    end
endmodule // tb
`default_nettype wire
